// *** verilog/prcs_defines.svh ***
// Purpose: constants for the reset-time clock configuration decoder
// Assumes: field codes are captured from the reset configuration word
// Notes: ratios are expressed as integer multiples
`ifndef PRCS_DEFINES_SVH
`define PRCS_DEFINES_SVH
`define PRCS_CORE_P1_D1 4'h0
`define PRCS_CORE_P1_D2 4'h1
`define PRCS_CORE_P2_D1 4'h4
`define PRCS_CORE_P2_D2 4'h5
`define PRCS_MEM_SYNC_CODE 5'h01
`define PRCS_PLAT_MIN 5'h04
`define PRCS_PLAT_MAX 5'h09
`define PRCS_BANK1_LANE_PAIRS 5
`endif

// *** verilog/prcs_pkg.sv ***
// Purpose: types for the clock configuration decoder
// Assumes: nothing
// Notes: core source enumeration is shared by decoder and top
`default_nettype none
package prcs_pkg;
	typedef enum logic [2:0] {
		PRCS_SRC_NONE = 3'h0,
		PRCS_SRC_P1_D1 = 3'h1,
		PRCS_SRC_P1_D2 = 3'h2,
		PRCS_SRC_P2_D1 = 3'h3,
		PRCS_SRC_P2_D2 = 3'h4
	} prcs_src_t;
	typedef enum logic [3:0] {
		PRCS_ST_IDLE = 4'b0001,
		PRCS_ST_LOAD = 4'b0010,
		PRCS_ST_DONE = 4'b0100,
		PRCS_ST_BAD = 4'b1000
	} prcs_state_t;
endpackage
`default_nettype wire

// *** verilog/prcs_core_if.sv ***
// Purpose: carries a core complex code and its decoded result
// Assumes: one instance per complex
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface prcs_core_if;
	import prcs_pkg::*;
	logic [3:0] code;
	logic upper;
	prcs_src_t src;
	logic bad;
	modport dec (input code, input upper, output src, output bad);
	modport top (output code, output upper, input src, input bad);
endinterface
`default_nettype wire

// *** verilog/prcs_core_dec.sv ***
// Purpose: decodes one core complex clock source select
// Assumes: code is stable while used
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
`include "prcs_defines.svh"
module prcs_core_dec
	import prcs_pkg::*;
(
	prcs_core_if.dec c
);
	always_comb begin
		c.src = PRCS_SRC_NONE;
		c.bad = 1'b0;
		case (c.code)
			`PRCS_CORE_P1_D1: c.src = PRCS_SRC_P1_D1;
			`PRCS_CORE_P1_D2: begin
				if (c.upper) c.bad = 1'b1;
				else c.src = PRCS_SRC_P1_D2;
			end
			`PRCS_CORE_P2_D1: c.src = PRCS_SRC_P2_D1;
			`PRCS_CORE_P2_D2: begin
				if (c.upper) c.src = PRCS_SRC_P2_D2;
				else c.bad = 1'b1;
			end
			default: c.bad = 1'b1;
		endcase
	end
endmodule // prcs_core_dec
`default_nettype wire

// *** verilog/prcs_clock_select.sv ***
// Purpose: captures reset configuration fields and decodes clock selections
// Assumes: i_load pulses once while the configuration fields are valid
// Notes: outputs are registered; o_valid or o_invalid rises two cycles after i_load
`timescale 1ns/1ps
`default_nettype none
`include "prcs_defines.svh"
module prcs_clock_select
	import prcs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_load,
	input wire logic [15:0] i_core_clock_source_select,
	input wire logic i_memory_sync,
	input wire logic [4:0] i_memory_pll_ratio,
	input wire logic [4:0] i_platform_pll_ratio,
	input wire logic [2:0] i_bank1_lane_pll_ratio,
	input wire logic [2:0] i_bank2_lane_pll_ratio,
	input wire logic [4:0] i_bank1_lane_divider,
	input wire logic i_bank2_lane_divider,
	input wire logic [1:0] i_packet_engine_clock_select,
	output logic [11:0] o_core_source,
	output logic o_memory_ref_platform,
	output logic [4:0] o_memory_multiple,
	output logic [3:0] o_platform_multiple,
	output logic [5:0] o_bank1_multiple,
	output logic [5:0] o_bank2_multiple,
	output logic [4:0] o_bank1_pair_div2,
	output logic o_bank2_div2,
	output logic [1:0] o_packet_engine_from_cluster_two,
	output logic o_valid,
	output logic o_invalid
);
	prcs_state_t state;
	logic [15:0] core_code;
	logic mem_sync;
	logic [4:0] mem_rat;
	logic [4:0] plat_rat;
	logic [2:0] b1_rat;
	logic [2:0] b2_rat;
	logic [`PRCS_BANK1_LANE_PAIRS-1:0] b1_div;
	logic b2_div;
	logic [1:0] pe_sel;
	logic [3:0] core_bad;
	prcs_src_t core_src [4];
	logic [4:0] next_mem_mult;
	logic [5:0] next_b1_mult;
	logic [5:0] next_b2_mult;
	logic cfg_bad;

	// lane ratio lookup; bank 1 only keeps the common codes
	function automatic logic [5:0] lane_mult(input logic [2:0] code, input logic bank2);
		case (code)
			3'h1: lane_mult = bank2 ? 6'h14 : 6'h00;
			3'h2: lane_mult = 6'h19;
			3'h3: lane_mult = 6'h28;
			3'h4: lane_mult = 6'h32;
			3'h5: lane_mult = bank2 ? 6'h18 : 6'h00;
			3'h6: lane_mult = bank2 ? 6'h1e : 6'h00;
			default: lane_mult = 6'h00;
		endcase
	endfunction

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_core
			prcs_core_if cif ();
			assign cif.code = core_code[4*g +: 4];
			assign cif.upper = (g >= 2) ? 1'b1 : 1'b0;
			assign core_src[g] = cif.src;
			assign core_bad[g] = cif.bad;
			prcs_core_dec u_dec (.c(cif));
		end
	endgenerate

	always_comb begin
		next_mem_mult = 5'h00;
		if (mem_sync) begin
			if (mem_rat == `PRCS_MEM_SYNC_CODE) next_mem_mult = 5'h01;
		end else begin
			case (mem_rat)
				5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h10, 5'h12:
					next_mem_mult = mem_rat;
				default: next_mem_mult = 5'h00;
			endcase
		end
		next_b1_mult = lane_mult(b1_rat, 1'b0);
		next_b2_mult = lane_mult(b2_rat, 1'b1);
	end

	assign cfg_bad = (|core_bad) || (next_mem_mult == 5'h00)
		|| (plat_rat < `PRCS_PLAT_MIN) || (plat_rat > `PRCS_PLAT_MAX)
		|| (next_b1_mult == 6'h00) || (next_b2_mult == 6'h00);

	// capture of the configuration fields
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			core_code <= 16'h0000;
			mem_sync <= 1'b0;
			mem_rat <= 5'h00;
			plat_rat <= 5'h00;
			b1_rat <= 3'h0;
			b2_rat <= 3'h0;
			b1_div <= 5'h00;
			b2_div <= 1'b0;
			pe_sel <= 2'h0;
		end else if (i_load && state == PRCS_ST_IDLE) begin
			core_code <= i_core_clock_source_select;
			mem_sync <= i_memory_sync;
			mem_rat <= i_memory_pll_ratio;
			plat_rat <= i_platform_pll_ratio;
			b1_rat <= i_bank1_lane_pll_ratio;
			b2_rat <= i_bank2_lane_pll_ratio;
			b1_div <= i_bank1_lane_divider;
			b2_div <= i_bank2_lane_divider;
			pe_sel <= i_packet_engine_clock_select;
		end
	end

	// sequencing
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= PRCS_ST_IDLE;
		end else begin
			case (state)
				PRCS_ST_IDLE: if (i_load) state <= PRCS_ST_LOAD;
				PRCS_ST_LOAD: state <= cfg_bad ? PRCS_ST_BAD : PRCS_ST_DONE;
				PRCS_ST_DONE: state <= PRCS_ST_DONE;
				PRCS_ST_BAD: state <= PRCS_ST_BAD;
				default: state <= PRCS_ST_IDLE;
			endcase
		end
	end

	// decoded outputs
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_core_source <= 12'h000;
			o_memory_ref_platform <= 1'b0;
			o_memory_multiple <= 5'h00;
			o_platform_multiple <= 4'h0;
			o_bank1_multiple <= 6'h00;
			o_bank2_multiple <= 6'h00;
			o_bank1_pair_div2 <= 5'h00;
			o_bank2_div2 <= 1'b0;
			o_packet_engine_from_cluster_two <= 2'h0;
			o_valid <= 1'b0;
			o_invalid <= 1'b0;
		end else if (state == PRCS_ST_LOAD) begin
			o_core_source <= {core_src[3], core_src[2], core_src[1], core_src[0]};
			o_memory_ref_platform <= mem_sync;
			o_memory_multiple <= next_mem_mult;
			o_platform_multiple <= cfg_bad ? 4'h0 : plat_rat[3:0];
			o_bank1_multiple <= next_b1_mult;
			o_bank2_multiple <= next_b2_mult;
			o_bank1_pair_div2 <= b1_div;
			o_bank2_div2 <= b2_div;
			o_packet_engine_from_cluster_two <= pe_sel;
			o_valid <= ~cfg_bad;
			o_invalid <= cfg_bad;
		end
	end

	a_valid_after_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == PRCS_ST_IDLE && i_load) |-> ##2 (o_valid ^ o_invalid))
		else $error("decode result missing two cycles after load");
	a_flags_exclusive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!(o_valid && o_invalid))
		else $error("valid and invalid both set");
	a_sync_mem_one: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(o_valid && o_memory_ref_platform) |-> o_memory_multiple == 5'h01)
		else $error("synchronous memory multiple not one");
	a_plat_range: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_valid |-> (o_platform_multiple >= 4'h4 && o_platform_multiple <= 4'h9))
		else $error("platform multiple out of range");
	a_bank1_legal: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_valid |-> (o_bank1_multiple inside {6'h19, 6'h28, 6'h32}))
		else $error("bank 1 multiple illegal");
	a_bank2_legal: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_valid |-> o_bank2_multiple != 6'h00)
		else $error("bank 2 multiple zero while valid");
	a_pe_follows: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_valid) |-> o_packet_engine_from_cluster_two == $past(pe_sel))
		else $error("packet engine select not taken");
	a_div_follows: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_valid) |-> (o_bank1_pair_div2 == $past(b1_div)
		&& o_bank2_div2 == $past(b2_div)))
		else $error("lane dividers not taken");
	a_core_legal: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_valid |-> (o_core_source[2:0] != 3'h0 && o_core_source[11:9] != 3'h0))
		else $error("core source none while valid");

	// checks on the decoded results
	a_mem_async_legal: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(o_valid && !o_memory_ref_platform) |-> (o_memory_multiple inside {5'h05, 5'h06,
		5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h10, 5'h12}))
		else $error("asynchronous memory multiple illegal");
	a_core_pair_legal: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_valid |-> (o_core_source[5:3] != 3'h0 && o_core_source[8:6] != 3'h0
		&& o_core_source[2:0] != 3'h4 && o_core_source[5:3] != 3'h4
		&& o_core_source[8:6] != 3'h2 && o_core_source[11:9] != 3'h2))
		else $error("core source not allowed for its complex");
	a_invalid_plat_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_invalid |-> o_platform_multiple == 4'h0)
		else $error("platform multiple shown while invalid");
	a_result_stands: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(o_valid || o_invalid) |=> ($stable(o_valid) && $stable(o_invalid)
		&& $stable(o_core_source) && $stable(o_memory_multiple)))
		else $error("decoded result changed before reset");
	a_ref_follows: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(o_valid || o_invalid) |-> o_memory_ref_platform == mem_sync)
		else $error("memory reference select not taken");
	a_bank_zero_bad: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(o_bank1_multiple == 6'h00 || o_bank2_multiple == 6'h00) |-> !o_valid)
		else $error("reserved lane ratio accepted");
	a_mem_zero_bad: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(o_memory_multiple == 5'h00) |-> !o_valid)
		else $error("reserved memory ratio accepted");
	a_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == PRCS_ST_IDLE) |-> (!o_valid && !o_invalid))
		else $error("result shown before any load");
	a_plat_follows: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_valid) |-> o_platform_multiple == $past(plat_rat[3:0]))
		else $error("platform multiple not taken");
	a_bank1_map: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_valid |-> o_bank1_multiple == ((b1_rat == 3'h2) ? 6'h19
		: (b1_rat == 3'h3) ? 6'h28 : 6'h32))
		else $error("bank 1 multiple does not match its code");
endmodule // prcs_clock_select
`default_nettype wire

// *** test/prcs_word_source.sv ***
// Purpose: reset configuration word source seen at power-up
// Assumes: field values come from the bench
// Notes: word is released once the load has been taken
`timescale 1ns/1ps
`default_nettype none
module prcs_word_source (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [40:0] i_fields,
	output logic o_load,
	output logic [40:0] o_fields
);
	logic [1:0] phase;
	// one load per reset, one cycle after reset release
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phase <= 2'h0;
		end else if (phase != 2'h2) begin
			phase <= phase + 2'h1;
		end
	end
	assign o_load = (phase == 2'h1);
	// all bits pass through from the bench until then; word inverted once released
	assign o_fields = (phase == 2'h2) ? ~i_fields : i_fields;
endmodule // prcs_word_source
`default_nettype wire

// *** test/pll_ratio_clock_select_test.sv ***
// Purpose: self-checking bench for the clock configuration decoder
// Assumes: word source model gives one load per reset
// Notes: every scenario starts from its own reset
`timescale 1ns/1ps
`default_nettype none
module pll_ratio_clock_select_test;
	logic i_clk, i_reset_n, load;
	logic [40:0] fields, f;
	logic [11:0] o_core_source;
	logic [4:0] o_memory_multiple, o_bank1_pair_div2;
	logic [3:0] o_platform_multiple;
	logic [5:0] o_bank1_multiple, o_bank2_multiple;
	logic [1:0] o_packet_engine_from_cluster_two;
	logic o_memory_ref_platform, o_bank2_div2, o_valid, o_invalid;
	int err_total, n_tests;
	prcs_word_source src (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_fields(fields),
		.o_load(load), .o_fields(f));
	prcs_clock_select dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_load(load),
		.i_core_clock_source_select(f[40:25]), .i_memory_sync(f[24]),
		.i_memory_pll_ratio(f[23:19]), .i_platform_pll_ratio(f[18:14]),
		.i_bank1_lane_pll_ratio(f[13:11]), .i_bank2_lane_pll_ratio(f[10:8]),
		.i_bank1_lane_divider(f[7:3]), .i_bank2_lane_divider(f[2]),
		.i_packet_engine_clock_select(f[1:0]), .o_core_source(o_core_source),
		.o_memory_ref_platform(o_memory_ref_platform), .o_memory_multiple(o_memory_multiple),
		.o_platform_multiple(o_platform_multiple), .o_bank1_multiple(o_bank1_multiple),
		.o_bank2_multiple(o_bank2_multiple), .o_bank1_pair_div2(o_bank1_pair_div2),
		.o_bank2_div2(o_bank2_div2), .o_valid(o_valid), .o_invalid(o_invalid),
		.o_packet_engine_from_cluster_two(o_packet_engine_from_cluster_two));
	task automatic tally_and_finish;
		if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value at %0d ns: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic run(input logic [40:0] v);
		int k;
		@(posedge i_clk);
		#1 i_reset_n = 1'b0;
		fields = v;
		repeat (2) @(posedge i_clk);
		#1 chk(12'({o_valid, o_invalid, o_memory_multiple, o_platform_multiple}), 12'h000);
		i_reset_n = 1'b1;
		for (k = 0; k < 10 && o_valid !== 1'b1 && o_invalid !== 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		chk(12'(k), 12'h003);
	endtask
	task automatic legal_async;
		run({16'h5410, 1'b0, 5'h12, 5'h04, 3'h2, 3'h1, 5'h15, 1'b1, 2'h2});
		chk(o_core_source, 12'h8d1);
		chk(12'(o_memory_ref_platform), 12'h000);
		chk(12'(o_memory_multiple), 12'h012);
		chk(12'(o_platform_multiple), 12'h004);
		chk({o_bank1_multiple, o_bank2_multiple}, 12'h654);
		chk(12'({o_bank1_pair_div2, o_bank2_div2}), 12'h02b);
		chk(12'(o_packet_engine_from_cluster_two), 12'h002);
		chk(12'({o_valid, o_invalid}), 12'h002);
	endtask
	task automatic legal_sync;
		run({16'h0044, 1'b1, 5'h01, 5'h09, 3'h4, 3'h6, 5'h0a, 1'b0, 2'h1});
		chk(o_core_source, 12'h25b);
		chk(12'({o_memory_ref_platform, o_memory_multiple}), 12'h021);
		chk(12'(o_platform_multiple), 12'h009);
		chk({o_bank1_multiple, o_bank2_multiple}, 12'hc9e);
		chk(12'({o_bank1_pair_div2, o_bank2_div2}), 12'h014);
		chk(12'(o_packet_engine_from_cluster_two), 12'h001);
		chk(12'({o_valid, o_invalid}), 12'h002);
	endtask
	task automatic ratio_table;
		logic [4:0] mem [0:8] = '{5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h10, 5'h12};
		logic [5:0] b1x [0:2] = '{6'h19, 6'h28, 6'h32};
		logic [5:0] b2x [0:5] = '{6'h14, 6'h19, 6'h28, 6'h32, 6'h18, 6'h1e};
		for (int i = 0; i < 9; i++) begin
			run({16'h5410, 1'b0, mem[i], 5'h04 + 5'(i % 6), 3'h2 + 3'(i % 3),
				3'h1 + 3'(i % 6), 8'h00});
			chk(12'(o_memory_multiple), 12'(mem[i]));
			chk(12'(o_platform_multiple), 12'(4'h4 + 4'(i % 6)));
			chk({o_bank1_multiple, o_bank2_multiple}, {b1x[i % 3], b2x[i % 6]});
			chk(12'({o_valid, o_invalid}), 12'h002);
		end
	endtask
	task automatic bad(input logic [40:0] v, input logic [11:0] core, input logic [4:0] mem,
		input logic [11:0] lanes);
		run(v);
		chk(12'({o_valid, o_invalid, o_platform_multiple}), 12'h010);
		chk(o_core_source, core);
		chk(12'(o_memory_multiple), 12'(mem));
		chk({o_bank1_multiple, o_bank2_multiple}, lanes);
	endtask
	task automatic reserved;
		bad({16'h5415, 1'b0, 5'h12, 5'h04, 3'h2, 3'h1, 8'h00}, 12'h8d0, 5'h12, 12'h654);
		bad({16'h5110, 1'b0, 5'h12, 5'h04, 3'h2, 3'h1, 8'h00}, 12'h811, 5'h12, 12'h654);
		bad({16'h5410, 1'b0, 5'h07, 5'h04, 3'h2, 3'h1, 8'h00}, 12'h8d1, 5'h00, 12'h654);
		bad({16'h5410, 1'b1, 5'h05, 5'h04, 3'h2, 3'h1, 8'h00}, 12'h8d1, 5'h00, 12'h654);
		bad({16'h5410, 1'b0, 5'h12, 5'h0a, 3'h2, 3'h1, 8'h00}, 12'h8d1, 5'h12, 12'h654);
		bad({16'h5410, 1'b0, 5'h12, 5'h04, 3'h1, 3'h1, 8'h00}, 12'h8d1, 5'h12, 12'h014);
		bad({16'h5410, 1'b0, 5'h12, 5'h04, 3'h2, 3'h7, 8'h00}, 12'h8d1, 5'h12, 12'h640);
	endtask
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	initial begin
		repeat (3000) @(posedge i_clk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		i_reset_n = 1'b0;
		fields = '0;
		err_total = 0;
		n_tests = 0;
		repeat (12) @(posedge i_clk);
		legal_async();
		legal_sync();
		ratio_table();
		reserved();
		tally_and_finish();
	end
endmodule // pll_ratio_clock_select_test
`default_nettype wire
